/* File: sys_counter_model.sv */
// Partner model: system counter that feeds the watchdog its count
`timescale 1ns/10ps
module sys_counter_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic load,
    input wire logic [63:0] load_value,
    output logic [63:0] system_count
);
    logic [63:0] count_q;
    logic [63:0] count_d;

    // Load wins over counting; holds while run and load are both low
    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_value;
        end else if (run) begin
            count_d = count_q + 64'h0000_0000_0000_0001;
        end
    end

    // Count register, cleared at power-up
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= 64'h0000_0000_0000_0000;
        end else begin
            count_q <= count_d;
        end
    end

    assign system_count = count_q;
endmodule

/* File: two_stage_system_watchdog.sv */
// Module: two-stage watchdog with Avalon-MM register slave
`timescale 1ns/10ps

module two_stage_system_watchdog (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [63:0] system_count,
    input wire logic [12:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic first_alert_signal,
    output logic second_alert_signal
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    wdog_pkg::bus_req_s req;
    wdog_pkg::bus_state_e bus_q, bus_d;
    logic [31:0] rdata_q, rdata_d;
    logic stall_q, stall_d;
    logic enable_q, enable_d;
    logic [47:0] offset_q, offset_d;
    logic [63:0] compare_q, compare_d;
    logic first_q, first_d;
    logic second_q, second_d;
    logic [63:0] count_q;
    logic timeout;
    logic accept_wr;
    logic software_reload_event;
    logic direct_compare_load;
    logic [11:0] ofs;
    logic ctrl_frame;

    // Word-aligned merge of byte lanes; partial writes keep old bytes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Identification word, same in both frames
    function automatic logic [31:0] ident_word();
        return {wdog_pkg::PRODUCT_ID, wdog_pkg::ARCH_VERSION,
                wdog_pkg::REVISION, wdog_pkg::IMPLEMENTER};
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign req = '{rd: read, wr: write, addr: address, be: byteenable,
                   wdata: writedata};
    assign ofs = req.addr[11:0];
    assign ctrl_frame = req.addr[wdog_pkg::FRAME_SEL_BIT];
    // Write takes effect in the first request cycle, while waitrequest is still high
    assign accept_wr = req.wr && (bus_q == wdog_pkg::BUS_IDLE);

    always_comb begin
        software_reload_event = 1'b0;
        direct_compare_load = 1'b0;
        if (accept_wr) begin
            if (!ctrl_frame) begin
                software_reload_event = (ofs == wdog_pkg::OFS_REFRESH_TRIGGER);
            end else begin
                software_reload_event =
                    (ofs == wdog_pkg::OFS_CONTROL_AND_STATUS) ||
                    (ofs == wdog_pkg::OFS_TIMEOUT_OFFSET_LOW) ||
                    (ofs == wdog_pkg::OFS_TIMEOUT_OFFSET_HIGH);
                direct_compare_load =
                    (ofs == wdog_pkg::OFS_COMPARE_VALUE_LOW) ||
                    (ofs == wdog_pkg::OFS_COMPARE_VALUE_HIGH);
            end
        end
    end

    assign timeout = (count_q > compare_q);

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, answer on the second
    // ------------------------------------------------------------
    always_comb begin
        bus_d = wdog_pkg::BUS_IDLE;
        rdata_d = rdata_q;
        if (bus_q == wdog_pkg::BUS_IDLE && (req.rd || req.wr)) begin
            bus_d = wdog_pkg::BUS_DONE;
            rdata_d = 32'h0000_0000;
            if (req.rd) begin
                if (ofs == wdog_pkg::OFS_IDENTIFICATION) begin
                    rdata_d = ident_word();
                end else if (ctrl_frame) begin
                    case (ofs)
                        wdog_pkg::OFS_CONTROL_AND_STATUS: begin
                            rdata_d = {29'h0, second_q, first_q, enable_q};
                        end
                        wdog_pkg::OFS_TIMEOUT_OFFSET_LOW: begin
                            rdata_d = offset_q[31:0];
                        end
                        wdog_pkg::OFS_TIMEOUT_OFFSET_HIGH: begin
                            rdata_d = {16'h0000, offset_q[47:32]};
                        end
                        wdog_pkg::OFS_COMPARE_VALUE_LOW: begin
                            rdata_d = compare_q[31:0];
                        end
                        wdog_pkg::OFS_COMPARE_VALUE_HIGH: begin
                            rdata_d = compare_q[63:32];
                        end
                        default: begin
                            rdata_d = 32'h0000_0000;
                        end
                    endcase
                end
            end
        end
        // Waitrequest low only in the answer cycle
        stall_d = (bus_d != wdog_pkg::BUS_DONE);
    end

    // Registered so waitrequest leaves a flop, not a gate
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bus_q <= wdog_pkg::BUS_IDLE;
            rdata_q <= 32'h0000_0000;
            stall_q <= 1'b1;
        end else begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
            stall_q <= stall_d;
        end
    end

    // ------------------------------------------------------------
    // Watchdog core
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wv;
        wv = 32'h0000_0000;
        enable_d = enable_q;
        offset_d = offset_q;
        compare_d = compare_q;
        first_d = first_q;
        second_d = second_q;
        if (accept_wr && ctrl_frame) begin
            case (ofs)
                wdog_pkg::OFS_CONTROL_AND_STATUS: begin
                    wv = merge({31'h0, enable_q}, req.wdata, req.be);
                    enable_d = wv[wdog_pkg::CS_ENABLE_BIT];
                end
                wdog_pkg::OFS_TIMEOUT_OFFSET_LOW: begin
                    offset_d[31:0] = merge(offset_q[31:0], req.wdata, req.be);
                end
                wdog_pkg::OFS_TIMEOUT_OFFSET_HIGH: begin
                    wv = merge({16'h0000, offset_q[47:32]}, req.wdata, req.be);
                    offset_d[47:32] = wv[15:0];
                end
                default: begin
                    wv = 32'h0000_0000;
                end
            endcase
        end
        if (direct_compare_load) begin
            if (ofs == wdog_pkg::OFS_COMPARE_VALUE_LOW) begin
                compare_d[31:0] = merge(compare_q[31:0], req.wdata, req.be);
            end else begin
                compare_d[63:32] = merge(compare_q[63:32], req.wdata, req.be);
            end
        end else if (software_reload_event || (timeout && !first_q)) begin
            // New offset, so an offset write takes effect at once
            compare_d = count_q + {16'h0000, offset_d};
        end
        if (!enable_q) begin
            first_d = 1'b0;
            second_d = 1'b0;
        end else if (software_reload_event) begin
            first_d = 1'b0;
            second_d = 1'b0;
        end else if (timeout) begin
            if (!first_q) begin
                first_d = 1'b1;
            end else begin
                second_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= wdog_pkg::RST_ENABLE;
            offset_q <= wdog_pkg::RST_OFFSET;
            compare_q <= wdog_pkg::RST_COMPARE;
            first_q <= 1'b0;
            second_q <= 1'b0;
            count_q <= 64'h0000_0000_0000_0000;
        end else begin
            enable_q <= enable_d;
            offset_q <= offset_d;
            compare_q <= compare_d;
            first_q <= first_d;
            second_q <= second_d;
            count_q <= system_count; // count updated every cycle, enabled or not
        end
    end

    assign first_alert_signal = first_q;
    assign second_alert_signal = second_q;
    assign readdata = rdata_q;
    assign waitrequest = stall_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_alert_clear;
        @(posedge sys_clk) disable iff (!nrst)
        software_reload_event |=> !first_q && !second_q;
    endproperty
    a_alert_clear: assert property (p_alert_clear)
        else $error("alerts not cleared by refresh");

    property p_disable;
        @(posedge sys_clk) disable iff (!nrst)
        !enable_q |=> !first_q && !second_q;
    endproperty
    a_disable: assert property (p_disable)
        else $error("alert while disabled");

    property p_first;
        @(posedge sys_clk) disable iff (!nrst)
        enable_q && timeout && !first_q && !software_reload_event
            |=> first_q;
    endproperty
    a_first: assert property (p_first)
        else $error("first alert missed");

    property p_second;
        @(posedge sys_clk) disable iff (!nrst)
        enable_q && timeout && first_q && !software_reload_event
            |=> second_q;
    endproperty
    a_second: assert property (p_second)
        else $error("second alert missed");

    property p_hold_cmp;
        @(posedge sys_clk) disable iff (!nrst)
        first_q && !software_reload_event && !direct_compare_load
            |=> $stable(compare_q);
    endproperty
    a_hold_cmp: assert property (p_hold_cmp)
        else $error("compare moved with first alert");

    property p_reload;
        @(posedge sys_clk) disable iff (!nrst)
        software_reload_event && !direct_compare_load
            |=> compare_q == $past(count_q) + {16'h0000, $past(offset_d)};
    endproperty
    a_reload: assert property (p_reload)
        else $error("bad reload value");

    property p_timeout_reload;
        @(posedge sys_clk) disable iff (!nrst)
        timeout && !first_q && !direct_compare_load
            |=> compare_q == $past(count_q) + {16'h0000, $past(offset_d)};
    endproperty
    a_timeout_reload: assert property (p_timeout_reload)
        else $error("bad timeout reload");

    property p_hold_alert;
        @(posedge sys_clk) disable iff (!nrst)
        second_q && enable_q && !software_reload_event |=> second_q;
    endproperty
    a_hold_alert: assert property (p_hold_alert)
        else $error("second alert dropped");

    property p_ack;
        @(posedge sys_clk) disable iff (!nrst)
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_ack: assert property (p_ack)
        else $error("no answer after one wait");

    property p_ident;
        @(posedge sys_clk) disable iff (!nrst)
        read && waitrequest && address[11:0] == 12'hFCC
            |=> readdata[19:16] == 4'h1;
    endproperty
    a_ident: assert property (p_ident)
        else $error("bad version field");

    property p_keep_first;
        @(posedge sys_clk) disable iff (!nrst)
        first_q && enable_q && !software_reload_event |=> first_q;
    endproperty
    a_keep_first: assert property (p_keep_first)
        else $error("timeout cleared first alert");

    property p_direct_low;
        @(posedge sys_clk) disable iff (!nrst)
        direct_compare_load && ofs == wdog_pkg::OFS_COMPARE_VALUE_LOW
            && req.be == 4'hF
            |=> compare_q[31:0] == $past(req.wdata);
    endproperty
    a_direct_low: assert property (p_direct_low)
        else $error("direct compare load lost");

    property p_stall_one;
        @(posedge sys_clk) disable iff (!nrst)
        !waitrequest |=> waitrequest;
    endproperty
    a_stall_one: assert property (p_stall_one)
        else $error("waitrequest low for two cycles");

    property p_refresh_read;
        @(posedge sys_clk) disable iff (!nrst)
        read && waitrequest && address == 13'h0000
            |=> readdata == 32'h0000_0000;
    endproperty
    a_refresh_read: assert property (p_refresh_read)
        else $error("refresh trigger read not zero");

    property p_status_read;
        @(posedge sys_clk) disable iff (!nrst)
        read && waitrequest && address == 13'h1000
            |=> readdata == {29'h0, $past(second_q), $past(first_q),
                             $past(enable_q)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("bad control word read");

    property p_offset_high;
        @(posedge sys_clk) disable iff (!nrst)
        read && waitrequest && address == 13'h100C
            |=> readdata[31:16] == 16'h0000;
    endproperty
    a_offset_high: assert property (p_offset_high)
        else $error("offset upper bits not zero");

endmodule

/* File: two_stage_system_watchdog_tb_top.sv */
// Testbench: register map and two-stage timeout of the watchdog
`timescale 1ns/10ps
module two_stage_system_watchdog_tb_top;
    localparam logic [12:0] A_CS = 13'h1000;
    localparam logic [12:0] A_OFL = 13'h1008;
    localparam logic [12:0] A_OFH = 13'h100C;
    localparam logic [12:0] A_CVL = 13'h1010;
    localparam logic [12:0] A_CVH = 13'h1014;
    localparam logic [63:0] C0 = 64'h0000_0001_FFFF_FFF0;
    logic sys_clk, nrst, read, write, run, load;
    logic first_alert_signal, second_alert_signal, waitrequest;
    logic [63:0] system_count, load_value, cv_a, cv_b;
    logic [12:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, q;
    int n_mismatch, comparisons;

    sys_counter_model sys_counter_model_inst (.sys_clk(sys_clk),
        .nrst(nrst), .run(run), .load(load), .load_value(load_value),
        .system_count(system_count));
    two_stage_system_watchdog two_stage_system_watchdog_inst (
        .sys_clk(sys_clk), .nrst(nrst), .system_count(system_count),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .first_alert_signal(first_alert_signal),
        .second_alert_signal(second_alert_signal));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task bus(input logic w, input logic [12:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 64);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        check({63'h0, n == 64}, 64'h0);
    endtask

    task rd_chk(input logic [12:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check({32'h0, q}, {32'h0, exp});
    endtask

    task rd_cv(output logic [63:0] v);
        bus(1'b0, A_CVL, 32'h0000_0000);
        v[31:0] = q;
        bus(1'b0, A_CVH, 32'h0000_0000);
        v[63:32] = q;
    endtask

    task set_count(input logic [63:0] v);
        @(posedge sys_clk);
        load <= 1'b1;
        load_value <= v;
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // Bounded wait for an alert to rise
    task wait_alert(input logic second);
        int n;
        n = 0;
        while (((second ? second_alert_signal : first_alert_signal)
                !== 1'b1) && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check({63'h0, n < 200}, 64'h1);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset_values;
        rd_chk(A_CS, 32'h0000_0000);
        rd_chk(13'h0000, 32'h0000_0000);
        rd_chk(13'h1004, 32'h0000_0000);
        rd_chk(A_OFH, 32'h0000_0000);
        rd_chk(A_CVH, 32'h0000_0000);
        bus(1'b0, 13'h0FCC, 32'h0000_0000);
        check({60'h0, q[19:16]}, 64'h1);
        bus(1'b0, 13'h1FCC, 32'h0000_0000);
        check({60'h0, q[19:16]}, 64'h1);
        $display("test reset_values done");
    endtask

    task t_refresh_reload;
        // Watchdog is still disabled while the count moves
        set_count(C0);
        bus(1'b1, A_OFH, 32'hFFFF_ABCD);
        rd_chk(A_OFH, 32'h0000_ABCD);
        bus(1'b1, A_OFL, 32'h8765_4321);
        rd_chk(A_OFL, 32'h8765_4321);
        rd_cv(cv_a);
        check(cv_a, C0 + 64'h0000_ABCD_8765_4321);
        bus(1'b1, A_CVL, 32'h1234_5678);
        bus(1'b1, A_CVH, 32'hFFFF_0000);
        rd_cv(cv_a);
        check(cv_a, 64'hFFFF_0000_1234_5678);
        bus(1'b1, 13'h0000, 32'h0000_0000);
        rd_cv(cv_a);
        check(cv_a, C0 + 64'h0000_ABCD_8765_4321);
        $display("test refresh_reload done");
    endtask

    task t_two_stage;
        bus(1'b1, A_OFH, 32'h0000_0000);
        bus(1'b1, A_OFL, 32'h0000_0014);
        bus(1'b1, A_CS, 32'h0000_0001);
        check({62'h0, second_alert_signal, first_alert_signal}, 64'h0);
        run <= 1'b1;
        wait_alert(1'b0);
        check({63'h0, second_alert_signal}, 64'h0);
        rd_cv(cv_a);
        check({63'h0, cv_a > C0 + 64'h14}, 64'h1);
        wait_alert(1'b1);
        rd_chk(A_CS, 32'h0000_0007);
        rd_cv(cv_a);
        repeat (30) @(posedge sys_clk);
        rd_cv(cv_b);
        check(cv_b, cv_a);
        rd_chk(A_OFL, 32'h0000_0014);
        check({62'h0, second_alert_signal, first_alert_signal}, 64'h3);
        run <= 1'b0;
        bus(1'b1, 13'h0000, 32'h0000_0000);
        @(posedge sys_clk);
        check({62'h0, second_alert_signal, first_alert_signal}, 64'h0);
        bus(1'b1, A_CS, 32'h0000_0007);
        rd_chk(A_CS, 32'h0000_0001);
        $display("test two_stage done");
    endtask

    task t_disabled;
        bus(1'b1, A_CS, 32'h0000_0000);
        bus(1'b1, A_CVH, 32'h0000_0000);
        bus(1'b1, A_CVL, 32'h0000_0000);
        repeat (20) begin
            @(posedge sys_clk);
            check({62'h0, second_alert_signal, first_alert_signal},
                  64'h0);
        end
        $display("test disabled done");
    endtask

    task conclude;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Whole run needs a few hundred cycles
    initial begin
        repeat (6000) @(posedge sys_clk);
        n_mismatch++;
        conclude();
    end

    initial begin
        nrst = 1'b0;
        {read, write, run, load} = 4'h0;
        address = 13'h0000;
        writedata = 32'h0000_0000;
        load_value = 64'h0000_0000_0000_0000;
        byteenable = 4'hF;
        n_mismatch = 0;
        comparisons = 0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset_values();
        t_refresh_reload();
        t_two_stage();
        t_disabled();
        conclude();
    end
endmodule

/* File: wdog_pkg.sv */
// Package: register map, field layout and reset values of the watchdog
package wdog_pkg;

    // ------------------------------------------------------------
    // Frame selection and register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [11:0] OFS_REFRESH_TRIGGER = 12'h000;
    localparam logic [11:0] OFS_CONTROL_AND_STATUS = 12'h000;
    localparam logic [11:0] OFS_TIMEOUT_OFFSET_LOW = 12'h008;
    localparam logic [11:0] OFS_TIMEOUT_OFFSET_HIGH = 12'h00C;
    localparam logic [11:0] OFS_COMPARE_VALUE_LOW = 12'h010;
    localparam logic [11:0] OFS_COMPARE_VALUE_HIGH = 12'h014;
    localparam logic [11:0] OFS_IDENTIFICATION = 12'hFCC;
    // Address bit 12 picks the frame: 0 refresh, 1 control
    localparam int FRAME_SEL_BIT = 12;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CS_ENABLE_BIT = 0;
    localparam int CS_FIRST_ALERT_BIT = 1;
    localparam int CS_SECOND_ALERT_BIT = 2;
    localparam int OFFSET_HIGH_W = 16;
    localparam int OFFSET_W = 48;
    localparam int ARCH_VERSION_LSB = 16;

    // ------------------------------------------------------------
    // Reset values and identification
    // ------------------------------------------------------------
    localparam logic RST_ENABLE = 1'b0;
    localparam logic [47:0] RST_OFFSET = 48'h0000_0000_0000;
    localparam logic [63:0] RST_COMPARE = 64'h0000_0000_0000_0000;
    localparam logic [3:0] ARCH_VERSION = 4'h1;
    // Arbitrary product, revision and implementer values
    localparam logic [11:0] PRODUCT_ID = 12'h000;
    localparam logic [3:0] REVISION = 4'h0;
    localparam logic [11:0] IMPLEMENTER = 12'h000;

    // Bus request as seen by the slave
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bus_req_s;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } bus_state_e;

endpackage
